// [fault_retry_sequencer.sv]
`timescale 1ns/1ns
`include "retry_map.svh"
// Contract
// R1 - retry code zero: no restart, output stays off until fault cleared; code also restarts on an off then on command (enable low, then high)
// R2 - codes one to six: exactly that many restarts, one per interval
// R3 - attempts used up without success: output off until fault cleared; code also restarts on an off then on command (enable low, then high)
// R4 - code seven: restart forever until off command, bias loss, other fault; code stops retrying only on off command (enable low)
// R5 - attempt spacing equals decoded delay count times delay unit
// R6 - delay code n means two to the power n units
// R7 - same delay sets how long operation continues after a fault
// R8 - unit duration comes from the separate unit register, not this one
// R9 - every mode sets the fault status bit and notifies the host
// R10 - mode three shuts down at once, then applies retry behaviour
// R11 - mode two limits current for delay, then retries if still limiting
// R12 - attempt budget reloads on fault clear or new enable; code lets a retry in the clear cycle count from the old budget
module fault_retry_sequencer #(
  parameter int UNIT_W = 16
) (
  input  wire logic              mclk,        // system clock
  input  wire logic              resetn,      // async reset, low
  input  wire logic              cfg_we,      // write fault-response reg
  input  wire logic [7:0]        cfg_wdata,   // write data
  output logic      [7:0]        cfg_rdata,   // fault-response readback
  input  wire logic              unit_we,     // write delay-unit reg
  input  wire logic [UNIT_W-1:0] unit_wdata,  // clocks per delay unit
  input  wire logic              enable,      // on command, same clock
  input  wire logic              oc_fault,    // over-current detected
  input  wire logic              low_vout,    // vout under lv limit
  input  wire logic              clear_fault, // clear faults pulse
  output logic                   out_en,      // output stage enable
  output logic                   cc_limit,    // hold current at limit
  output logic                   fault_flag,  // sticky status bit
  output logic                   host_alert,  // notify host, level
  output logic [2:0]             attempts_left// remaining budget
);
  logic [7:0]        cfg_q, cfg_d;
  logic [UNIT_W-1:0] unit_q, unit_d;
  retry_pkg::seq_state_t st_q, st_d;
  logic [2:0]        left_q, left_d;
  logic              flag_q, flag_d;
  logic              en_q;
  logic              tmr_start;
  logic              tmr_exp;
  logic [1:0]        resp;
  logic [2:0]        retry;
  logic              go_retry;
  logic [31:0]       dwell_q, dwell_d;
  logic              calm_q, calm_d;
  logic [31:0]       span;

  assign resp  = cfg_q[`RESP_MSB:`RESP_LSB];
  assign retry = cfg_q[`RETRY_MSB:`RETRY_LSB];

  delay_timer #(.UNIT_W(UNIT_W)) u_tmr (
    .mclk        (mclk),
    .resetn      (resetn),
    .start       (tmr_start),
    .code        (cfg_q[`DELAY_MSB:`DELAY_LSB]),
    .unit_cycles (unit_q),              // [R8]
    .expired     (tmr_exp)
  );

  always_comb
  begin
    cfg_d  = cfg_we ? cfg_wdata : cfg_q;
    unit_d = unit_we ? unit_wdata : unit_q;
    // set wins over clear for the status bit
    flag_d = flag_q;
    if (clear_fault)
      flag_d = 1'b0;
    if (oc_fault && st_q != retry_pkg::ST_OFF)
      flag_d = 1'b1;                                  // [R9]
  end

  always_comb
  begin
    st_d      = st_q;
    left_d    = left_q;
    tmr_start = 1'b0;
    go_retry  = 1'b0;
    if (clear_fault || (enable && !en_q))
      left_d = retry;                                 // [R12]
    case (st_q)
      retry_pkg::ST_OFF:
        if (enable && !en_q)
          st_d = retry_pkg::ST_RUN;
      retry_pkg::ST_RUN:
        if (!enable)
          st_d = retry_pkg::ST_OFF;
        else if (oc_fault)
        begin
          case (resp)
            `RESP_SHUTDOWN: go_retry = 1'b1;          // [R10]
            `RESP_DELAYCC:
            begin
              st_d      = retry_pkg::ST_LIMIT;        // [R11]
              tmr_start = 1'b1;                       // [R7]
            end
            `RESP_CONDCC: if (low_vout) go_retry = 1'b1;
            default: ;
          endcase
        end
      retry_pkg::ST_LIMIT:
        if (!enable)
          st_d = retry_pkg::ST_OFF;
        else if (tmr_exp)
        begin
          if (oc_fault)
            go_retry = 1'b1;                          // [R11]
          else
            st_d = retry_pkg::ST_RUN;
        end
      retry_pkg::ST_WAIT:
        if (!enable)
          st_d = retry_pkg::ST_OFF;                   // [R4]
        else if (tmr_exp)
          st_d = retry_pkg::ST_RUN;                   // [R5]
      retry_pkg::ST_LATCHED:
        if (clear_fault || (enable && !en_q))
          st_d = enable ? retry_pkg::ST_RUN : retry_pkg::ST_OFF;
        else if (!enable)
          st_d = retry_pkg::ST_OFF;
      default:
        st_d = retry_pkg::ST_OFF;
    endcase
    if (go_retry)
    begin
      if (retry == `RETRY_FOREVER)
      begin
        st_d      = retry_pkg::ST_WAIT;               // [R4]
        tmr_start = 1'b1;
      end
      else if (retry == `RETRY_NONE || left_q == `RETRY_NONE)
        st_d = retry_pkg::ST_LATCHED;                 // [R1] [R3]
      else
      begin
        st_d      = retry_pkg::ST_WAIT;               // [R2]
        left_d    = left_q - 3'h1;
        tmr_start = 1'b1;                             // [R5]
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_q  <= `CFG_RESET;
      unit_q <= UNIT_W'(`UNIT_RESET);
      st_q   <= retry_pkg::ST_OFF;
      left_q <= `RETRY_NONE;
      flag_q <= 1'b0;
      en_q   <= 1'b0;
    end
    else
    begin
      cfg_q  <= cfg_d;
      unit_q <= unit_d;
      st_q   <= st_d;
      left_q <= left_d;
      flag_q <= flag_d;
      en_q   <= enable;
    end
  end

  assign cfg_rdata     = cfg_q;
  assign out_en        = (st_q == retry_pkg::ST_RUN) ||
                         (st_q == retry_pkg::ST_LIMIT);
  assign cc_limit      = (st_q == retry_pkg::ST_LIMIT);
  assign fault_flag    = flag_q;
  assign host_alert    = flag_q;                      // [R9]
  assign attempts_left = left_q;

  // check-only: cycles spent in the present state, and whether the
  // delay settings stayed untouched since it was entered
  always_comb
  begin
    span    = 32'((32'h1 << cfg_q[`DELAY_MSB:`DELAY_LSB]) * unit_q);
    dwell_d = dwell_q + 32'h1;
    calm_d  = calm_q && !cfg_we && !unit_we;
    if (st_d != st_q)
    begin
      dwell_d = 32'h0;
      calm_d  = !cfg_we && !unit_we;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dwell_q <= 32'h0;
      calm_q  <= 1'b0;
    end
    else
    begin
      dwell_q <= dwell_d;
      calm_q  <= calm_d;
    end
  end

  AST_NO_RETRY: assert property (@(posedge mclk) // [R1]
    disable iff (!resetn)
    (st_q == retry_pkg::ST_RUN && oc_fault && enable &&
     resp == `RESP_SHUTDOWN && retry == `RETRY_NONE)
    |=> st_q == retry_pkg::ST_LATCHED)
    else $error("no-retry fault did not latch off");
  AST_COUNT_DOWN: assert property (@(posedge mclk) // [R2]
    disable iff (!resetn)
    (go_retry && retry != `RETRY_FOREVER && retry != `RETRY_NONE &&
     left_q != `RETRY_NONE && !clear_fault && en_q)
    |=> left_q == $past(left_q) - 3'h1)
    else $error("attempt budget not decremented");
  AST_LATCH_HOLD: assert property (@(posedge mclk) // [R3]
    disable iff (!resetn)
    (st_q == retry_pkg::ST_LATCHED && !clear_fault && enable && en_q)
    |=> st_q == retry_pkg::ST_LATCHED && !out_en)
    else $error("latched fault released without clear");
  AST_FOREVER: assert property (@(posedge mclk) // [R4]
    disable iff (!resetn)
    (st_q == retry_pkg::ST_RUN && oc_fault && enable &&
     resp == `RESP_SHUTDOWN && retry == `RETRY_FOREVER)
    |=> st_q == retry_pkg::ST_WAIT)
    else $error("continuous retry stopped");
  AST_WAIT_OFF: assert property (@(posedge mclk) // [R5]
    disable iff (!resetn)
    (st_q == retry_pkg::ST_WAIT && enable && !tmr_exp)
    |=> st_q == retry_pkg::ST_WAIT && !out_en)
    else $error("output on during retry interval");
  AST_GAP: assert property (@(posedge mclk) // [R5] [R6]
    disable iff (!resetn)
    (st_q == retry_pkg::ST_WAIT && tmr_exp && calm_q && unit_q != '0)
    |-> dwell_q == span)
    else $error("retry interval length wrong");
  AST_HOLD_TIME: assert property (@(posedge mclk) // [R7]
    disable iff (!resetn)
    (st_q == retry_pkg::ST_LIMIT && tmr_exp && calm_q && unit_q != '0)
    |-> dwell_q == span)
    else $error("current-limit hold length wrong");
  AST_SHUT_NOW: assert property (@(posedge mclk) // [R10]
    disable iff (!resetn)
    (st_q == retry_pkg::ST_RUN && enable && oc_fault &&
     resp == `RESP_SHUTDOWN)
    |=> !out_en)
    else $error("mode three did not shut down at once");
  AST_LIMIT: assert property (@(posedge mclk) // [R11]
    disable iff (!resetn)
    (st_q == retry_pkg::ST_RUN && enable && oc_fault &&
     resp == `RESP_DELAYCC)
    |=> cc_limit && out_en)
    else $error("mode two did not hold current limit");
  AST_FLAG: assert property (@(posedge mclk) // [R9]
    disable iff (!resetn)
    (oc_fault && st_q != retry_pkg::ST_OFF) |=> fault_flag && host_alert)
    else $error("fault status bit not set");
  AST_RELOAD: assert property (@(posedge mclk) // [R12]
    disable iff (!resetn)
    clear_fault && !go_retry |=> left_q == $past(retry))
    else $error("attempt budget not reloaded");
  COV_LATCH: cover property (@(posedge mclk) st_q == retry_pkg::ST_LATCHED);
  COV_WAIT_RUN: cover property (@(posedge mclk)
    st_q == retry_pkg::ST_WAIT ##1 st_q == retry_pkg::ST_RUN);
  COV_LIMIT: cover property (@(posedge mclk) tmr_exp && cc_limit);
  COV_FOREVER_WAIT: cover property (@(posedge mclk)
    st_q == retry_pkg::ST_WAIT && retry == `RETRY_FOREVER);
  COV_COND_SHUT: cover property (@(posedge mclk)
    st_q == retry_pkg::ST_RUN && resp == `RESP_CONDCC && oc_fault && low_vout);
endmodule

// [retry_map.svh]
`ifndef RETRY_MAP_SVH
`define RETRY_MAP_SVH
`define RESP_MSB       7
`define RESP_LSB       6
`define RETRY_MSB      5
`define RETRY_LSB      3
`define DELAY_MSB      2
`define DELAY_LSB      0
`define RETRY_NONE     3'h0
`define RETRY_FOREVER  3'h7
`define RESP_IGNORE    2'h0
`define RESP_CONDCC    2'h1
`define RESP_DELAYCC   2'h2
`define RESP_SHUTDOWN  2'h3
`define CFG_RESET      8'hc0
`define UNIT_RESET     16'h0064
`endif

// [retry_pkg.sv]
package retry_pkg;
  typedef enum logic [2:0]
  {
    ST_OFF     = 3'b000,
    ST_RUN     = 3'b001,
    ST_LIMIT   = 3'b010,
    ST_WAIT    = 3'b011,
    ST_LATCHED = 3'b100
  } seq_state_t;
endpackage

// [delay_timer.sv]
`timescale 1ns/1ns
`include "retry_map.svh"
// counts (2**code) delay units, each unit_cycles clocks long
module delay_timer #(
  parameter int UNIT_W = 16
) (
  input  wire logic              mclk,       // system clock
  input  wire logic              resetn,     // async reset, low
  input  wire logic              start,      // restart the interval
  input  wire logic [2:0]        code,       // delay field
  input  wire logic [UNIT_W-1:0] unit_cycles,// clocks per unit
  output logic                   expired     // one-cycle pulse at end
);
  logic [UNIT_W-1:0] ucnt_q, ucnt_d;
  logic [7:0]        ncnt_q, ncnt_d;
  logic              run_q, run_d;
  logic              exp_d;

  always_comb
  begin
    ucnt_d = ucnt_q;
    ncnt_d = ncnt_q;
    run_d  = run_q;
    exp_d  = 1'b0;
    if (start)
    begin
      run_d  = 1'b1;
      ucnt_d = '0;
      ncnt_d = 8'(8'h01 << code) - 8'h01; // [R6]
    end
    else if (run_q)
    begin
      if (ucnt_q + UNIT_W'(1) >= unit_cycles)
      begin
        ucnt_d = '0;
        if (ncnt_q == 8'h00)
        begin
          run_d = 1'b0;
          exp_d = 1'b1;
        end
        else
          ncnt_d = ncnt_q - 8'h01;
      end
      else
        ucnt_d = ucnt_q + UNIT_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ucnt_q  <= '0;
      ncnt_q  <= 8'h00;
      run_q   <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      ucnt_q  <= ucnt_d;
      ncnt_q  <= ncnt_d;
      run_q   <= run_d;
      expired <= exp_d;
    end
  end
endmodule

// [host_model.sv]
`timescale 1ns/1ns
module host_model (
  input  wire logic   mclk,       // system clock
  output logic        cfg_we,     // fault-response write
  output logic [7:0]  cfg_wdata,  // fault-response data
  output logic        unit_we,    // delay-unit write
  output logic [15:0] unit_wdata  // clocks per delay unit
);
  initial
  begin
    cfg_we = 1'b0;
    unit_we = 1'b0;
    cfg_wdata = 8'h00;
    unit_wdata = 16'h0000;
  end
  // unit length lives in its own register
  task write(input logic sel, input logic [15:0] v);
    @(negedge mclk);
    cfg_we = ~sel;
    unit_we = sel;
    cfg_wdata = v[7:0];
    unit_wdata = v;
    @(negedge mclk);
    cfg_we = 1'b0;
    unit_we = 1'b0;
    // released data is scrambled so a stale value cannot pass
    cfg_wdata = ~v[7:0];
    unit_wdata = ~v;
  endtask
endmodule

// [fault_retry_sequencer_bench.sv]
`timescale 1ns/1ns
`include "retry_map.svh"
module fault_retry_sequencer_bench;
  localparam int U = 2;
  logic        mclk, resetn, enable, oc_fault, clear_fault, low_vout;
  logic        cfg_we, unit_we, out_en, cc_limit, fault_flag, host_alert;
  logic [7:0]  cfg_wdata, cfg_rdata;
  logic [15:0] unit_wdata;
  logic [2:0]  attempts_left;
  int          err_total, n_checks, seed, cyc, rises, lowrun, first_low;
  int          gap_q [$];
  // retry codes covering none, small, max finite and unlimited
  logic [2:0]  seed_list [6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  fault_retry_sequencer dut (.mclk(mclk), .resetn(resetn),
    .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .unit_we(unit_we), .unit_wdata(unit_wdata), .enable(enable),
    .oc_fault(oc_fault), .low_vout(low_vout), .clear_fault(clear_fault),
    .out_en(out_en), .cc_limit(cc_limit), .fault_flag(fault_flag),
    .host_alert(host_alert), .attempts_left(attempts_left));
  host_model host (.mclk(mclk), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
    .unit_we(unit_we), .unit_wdata(unit_wdata));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end
  task check(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task run(logic [1:0] mode, logic [2:0] r, logic [2:0] d);
    int lim, t, wait_c;
    logic quiet;
    // modes that keep running through the fault
    quiet = mode == `RESP_IGNORE || (mode == `RESP_CONDCC && !low_vout);
    wait_c = (1 << d) * U;
    lim = 10 * (2 * wait_c + 6) + 20;
    gap_q.delete();
    // model: one expected off-interval per allowed restart
    repeat (quiet ? 0 : (r == `RETRY_FOREVER ? 16 : int'(r)))
      gap_q.push_back(wait_c + 1);
    host.write(1'b0, {8'h00, mode, r, d});
    check("cfg_rdata", cfg_rdata, {mode, r, d});
    enable = 1'b0;
    repeat (2) @(negedge mclk);
    enable = 1'b1;
    repeat (2) @(negedge mclk);
    check("out_en", out_en, 8'h01);
    check("attempts_left", attempts_left, r);
    oc_fault = 1'b1;
    rises = 0;
    lowrun = 0;
    first_low = 0;
    for (t = 0; t < lim; t++)
    begin
      @(negedge mclk);
      if (t == 1 && mode == `RESP_DELAYCC)
        check("cc_limit", cc_limit, 8'h01);
      if (out_en === 1'b0)
        lowrun++;
      else if (lowrun > 0)
      begin
        rises++;
        if (first_low == 0)
          first_low = lowrun;
        if (gap_q.size() > 0)
          check("gap_q", 8'(lowrun), 8'(gap_q.pop_front()));
        lowrun = 0;
      end
    end
    check("fault_flag", fault_flag, 8'h01);
    check("host_alert", host_alert, 8'h01);
    if (quiet)
    begin
      check("rises", 8'(rises), 8'h00);
      check("out_en", out_en, 8'h01);
    end
    else if (r == `RETRY_FOREVER)
      check("many", 8'(rises >= 7), 8'h01);
    else
    begin
      check("rises", 8'(rises), r);
      check("out_en", out_en, 8'h00);
      check("gap_q left", 8'(gap_q.size()), 8'h00);
    end
    if (!quiet && r != `RETRY_NONE)
      check("gap", 8'(first_low), 8'(wait_c + 1));
    oc_fault = 1'b0;
    clear_fault = 1'b1;
    @(negedge mclk);
    clear_fault = 1'b0;
    repeat (2) @(negedge mclk);
    check("flag clr", fault_flag, 8'h00);
    enable = 1'b0;
  endtask
  initial
  begin
    resetn = 1'b0;
    enable = 1'b0;
    oc_fault = 1'b0;
    clear_fault = 1'b0;
    low_vout = 1'b0;
    seed = 86;
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    check("cfg reset", cfg_rdata, `CFG_RESET);
    host.write(1'b1, 16'(U));
    foreach (seed_list[i])
      run(`RESP_SHUTDOWN, seed_list[i], 3'($unsigned($random(seed)) % 3));
    run(`RESP_DELAYCC, 3'h1, 3'h1);
    run(`RESP_IGNORE, 3'h2, 3'h0);
    run(`RESP_CONDCC, 3'h1, 3'h0);
    low_vout = 1'b1;
    run(`RESP_CONDCC, 3'h2, 3'h1);
    low_vout = 1'b0;
    summarize();
  end
endmodule
